// File: rtl/pfs_pkg.sv
// Constants, types and address decode shared by the pin select block.
// Assumes a 32-bit AXI4-Lite register bus and three 32-bit shared ports.
package pfs_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [31:0] SEL2_ADDR   = 32'hE002C014;
   localparam logic [31:0] GPIO_BASE   = 32'hE0028000;
   localparam logic [31:0] GPIO_STRIDE = 32'h00000010;
   localparam logic [3:0]  OFF_PIN     = 4'h0;
   localparam logic [3:0]  OFF_SET     = 4'h4;
   localparam logic [3:0]  OFF_DIR     = 4'h8;
   localparam logic [3:0]  OFF_CLR     = 4'hC;
   localparam int          NPORT       = 3;

   // ---------------------------------------------------------------
   // Select register layout
   // ---------------------------------------------------------------
   localparam logic [31:0] SEL2_WMASK  = 32'h0FF3E9FC;
   localparam logic [31:0] SEL2_RST    = 32'h00600080;
   localparam int BIT_DBG  = 2;
   localparam int BIT_TRC  = 3;
   localparam int WID_LO   = 4;
   localparam int BIT_ANALOG_IN_6 = 6;
   localparam int BIT_ANALOG_IN_7 = 7;
   localparam int BIT_WE   = 8;
   localparam int BIT_CS1  = 11;
   localparam int BIT_EXT_CLOCK_OUT = 13;
   localparam int CS2_LO   = 14;
   localparam int CS3_LO   = 16;
   localparam int BIT_P2HI = 20;
   localparam int BIT_ANALOG_IN_4 = 21;
   localparam int BIT_ANALOG_IN_5 = 22;
   localparam int BIT_A0   = 23;
   localparam int BIT_A1   = 24;
   localparam int ADR_LO   = 25;

   localparam logic [1:0] WID_GPIO = 2'h3;
   localparam logic [1:0] WID_32   = 2'h2;
   localparam logic [1:0] WID_16   = 2'h1;
   localparam logic [1:0] CS_ON    = 2'h1;
   localparam logic [1:0] BOOT_W8  = 2'h0;
   localparam logic [1:0] BOOT_NO  = 2'h3;
   localparam logic [2:0] ADR_NONE = 3'h0;
   localparam logic [2:0] ADR_ALL  = 3'h7;

   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } pfs_pad_t;

   // Address lines enabled from bit 2 upward, per field value
   function automatic logic [23:0] pfs_adr_mask(input logic [2:0] f);
      case (f)
         3'h0:    pfs_adr_mask = 24'h000000;
         3'h1:    pfs_adr_mask = 24'h00000C;
         3'h2:    pfs_adr_mask = 24'h00003C;
         3'h3:    pfs_adr_mask = 24'h0000FC;
         3'h4:    pfs_adr_mask = 24'h000FFC;
         3'h5:    pfs_adr_mask = 24'h00FFFC;
         3'h6:    pfs_adr_mask = 24'h0FFFFC;
         default: pfs_adr_mask = 24'hFFFFFC;
      endcase
   endfunction

endpackage

// File: rtl/pfs_pin_select.sv
// Pin function selection for the third select register plus GPIO ports.
// Assumes peripherals on clk_i and pads from outside the clock domain.
//
// Overview of operation
// - Direction register only governs pins in GPIO mode.
// - Bit 2 gives upper port-1 pins to debug.
// - Bit 3 gives port-1 pins 25..16 to trace.
// - Width field enables low data, strobes, selects.
// - Value 10 alone enables upper data, lanes 2-3.
// - Bits 6,7 pick analog 6,7 unless width is 10; bit 7 resets high.
// - Bits 21,22 pick analog 4,5 unless width is 10; reset high.
// - Bit 20 unused; width 10 gives port-2 29:28 data.
// - Bit 8 gives port-3 pin 27 write enable.
// - Bit 11 gives port-3 pin 26 chip select 1.
// - Bit 13 gives pin 23 the clock output unless field 27:25 is 111.
// - Field 15:14 value 01 drives chip select 2.
// - Field 17:16 value 01 drives chip select 3.
// - Bit 23 picks address 0; boot 00 sets it.
// - Bit 24 picks address 1; reset from boot 1.
// - Field 27:25 enables address lines from bit 2.
// - Per-pin direction; all inputs after reset.
// - Separate set and clear write registers.
// - Reads return output register and live pins.
`timescale 1ns/1ns
`default_nettype none

module pfs_pin_select (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   // AXI4-Lite slave
   input  wire logic [31:0]             s_axi_awaddr_i,
   input  wire logic                    s_axi_awvalid_i,
   output logic                         s_axi_awready_o,
   input  wire logic [31:0]             s_axi_wdata_i,
   input  wire logic [3:0]              s_axi_wstrb_i,
   input  wire logic                    s_axi_wvalid_i,
   output logic                         s_axi_wready_o,
   output logic [1:0]                   s_axi_bresp_o,
   output logic                         s_axi_bvalid_o,
   input  wire logic                    s_axi_bready_i,
   input  wire logic [31:0]             s_axi_araddr_i,
   input  wire logic                    s_axi_arvalid_i,
   output logic                         s_axi_arready_o,
   output logic [31:0]                  s_axi_rdata_o,
   output logic [1:0]                   s_axi_rresp_o,
   output logic                         s_axi_rvalid_o,
   input  wire logic                    s_axi_rready_i,
   // Boot straps, sampled while reset is held
   input  wire logic [1:0]              boot_strap_pins_i,
   // Memory controller side
   input  wire logic [31:0]             mem_dout_i,
   input  wire logic                    mem_doe_i,
   input  wire logic [23:0]             mem_addr_i,
   input  wire logic [3:0]              mem_cs_n_i,
   input  wire logic                    mem_oe_n_i,
   input  wire logic                    mem_we_n_i,
   input  wire logic [3:0]              mem_bls_n_i,
   input  wire logic                    ext_clock_out_i,
   output logic [31:0]                  mem_din_o,
   // Debug and trace side
   input  wire logic [5:0]              dbg_out_i,
   input  wire logic [5:0]              dbg_oe_i,
   input  wire logic [9:0]              trace_i,
   output logic [5:0]                   dbg_in_o,
   // Analog input enables, bits 4..7 of the converter
   output logic [3:0]                   analog_in_en_o,
   // Pads of ports 1, 2, 3 (index 0, 1, 2)
   input  wire logic [2:0][31:0]        pad_i,
   output pfs_pkg::pfs_pad_t [2:0]      pad_o
);

   // ---------------------------------------------------------------
   // Pad and strap synchronisers
   // ---------------------------------------------------------------
   logic [2:0][31:0] pad_s1_q;
   logic [2:0][31:0] pad_s2_q;
   logic [1:0]       boot_s1_q;
   logic [1:0]       boot_s2_q;

   always_ff @(posedge clk_i) begin
      pad_s1_q  <= pad_i;
      pad_s2_q  <= pad_s1_q;
      boot_s1_q <= boot_strap_pins_i;
      boot_s2_q <= boot_s1_q;
   end

   // ---------------------------------------------------------------
   // Select register fields
   // ---------------------------------------------------------------
   logic [31:0] sel_q;
   wire  [1:0]  wid      = sel_q[pfs_pkg::WID_LO +: 2];
   wire  [1:0]  cs2_f    = sel_q[pfs_pkg::CS2_LO +: 2];
   wire  [1:0]  cs3_f    = sel_q[pfs_pkg::CS3_LO +: 2];
   wire  [2:0]  adr_f    = sel_q[pfs_pkg::ADR_LO +: 3];
   wire         bus8     = (wid != pfs_pkg::WID_GPIO);
   wire         bus16    = (wid == pfs_pkg::WID_16) |
                           (wid == pfs_pkg::WID_32);
   wire         bus32    = (wid == pfs_pkg::WID_32);
   wire  [23:0] adrm     = pfs_pkg::pfs_adr_mask(adr_f);
   wire         a23_on   = (adr_f == pfs_pkg::ADR_ALL);
   wire         ext_clock_out_on  = ~a23_on & sel_q[pfs_pkg::BIT_EXT_CLOCK_OUT];
   wire         analog_in_4     = ~bus32 & sel_q[pfs_pkg::BIT_ANALOG_IN_4];
   wire         analog_in_5     = ~bus32 & sel_q[pfs_pkg::BIT_ANALOG_IN_5];
   wire         analog_in_6     = ~bus32 & sel_q[pfs_pkg::BIT_ANALOG_IN_6];
   wire         analog_in_7     = ~bus32 & sel_q[pfs_pkg::BIT_ANALOG_IN_7];

   // Boot-derived reset image of the select register
   wire  [31:0] sel_boot;
   assign sel_boot = pfs_pkg::SEL2_RST
      | ({30'h0, boot_s2_q} << pfs_pkg::WID_LO)
      | ({31'h0, boot_s2_q == pfs_pkg::BOOT_W8} << pfs_pkg::BIT_A0)
      | ({31'h0, boot_s2_q[1]} << pfs_pkg::BIT_A1)
      | ({29'h0, (boot_s2_q == pfs_pkg::BOOT_NO) ? pfs_pkg::ADR_NONE
                                               : pfs_pkg::ADR_ALL}
         << pfs_pkg::ADR_LO);

   // ---------------------------------------------------------------
   // Function ownership per pin
   // ---------------------------------------------------------------
   logic [2:0][31:0] fmask;
   logic [2:0][31:0] fout;
   logic [2:0][31:0] foe;

   // Port 1: selects, trace, debug
   assign fmask[0] = {{6{sel_q[pfs_pkg::BIT_DBG]}},
                      {10{sel_q[pfs_pkg::BIT_TRC]}},
                      14'h0000, bus8, bus8};
   assign fout[0]  = {dbg_out_i, trace_i, 14'h0000,
                      mem_oe_n_i, mem_cs_n_i[0]};
   assign foe[0]   = {dbg_oe_i, 10'h3FF, 14'h0000, 2'h3};

   // Port 2: data bus, analog 4 and 5 on the top pair
   // Reserved bit 20 is unused; 29:28 follow the 32-bit width
   assign fmask[1] = {bus32 | analog_in_5, bus32 | analog_in_4, {14{bus32}},
                      {8{bus16}}, {8{bus8}}};
   assign fout[1]  = mem_dout_i;
   assign foe[1]   = {{2{mem_doe_i & bus32}}, {30{mem_doe_i}}};

   // Port 3: lanes, strobes, selects, address
   assign fmask[2] = {bus8, bus16,
                      bus32 | analog_in_6, bus32 | analog_in_7,
                      sel_q[pfs_pkg::BIT_WE],
                      sel_q[pfs_pkg::BIT_CS1],
                      cs2_f == pfs_pkg::CS_ON,
                      cs3_f == pfs_pkg::CS_ON,
                      a23_on | ext_clock_out_on,
                      adrm[22:2],
                      sel_q[pfs_pkg::BIT_A1],
                      sel_q[pfs_pkg::BIT_A0]};
   assign fout[2]  = {mem_bls_n_i[0], mem_bls_n_i[1],
                      mem_bls_n_i[2], mem_bls_n_i[3],
                      mem_we_n_i, mem_cs_n_i[1],
                      mem_cs_n_i[2], mem_cs_n_i[3],
                      a23_on ? mem_addr_i[23] : ext_clock_out_i,
                      mem_addr_i[22:0]};
   // Analog pins are inputs: function owns them but never drives
   assign foe[2]   = {2'h3, bus32, bus32, 28'hFFFFFFF};

   // ---------------------------------------------------------------
   // AXI4-Lite handshake state
   // ---------------------------------------------------------------
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   wire aw_hs  = s_axi_awvalid_i & awready_q;
   wire w_hs   = s_axi_wvalid_i & wready_q;
   wire ar_hs  = s_axi_arvalid_i & arready_q;
   wire do_wr  = ~awready_q & ~wready_q & ~bvalid_q;
   wire b_done = bvalid_q & s_axi_bready_i;
   wire r_done = rvalid_q & s_axi_rready_i;

   // Byte strobes widened to a bit mask
   wire [31:0] wbits = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   wire        wr_sel  = (awaddr_q == pfs_pkg::SEL2_ADDR);
   wire [31:0] wr_off  = awaddr_q - pfs_pkg::GPIO_BASE;
   wire [31:0] rd_off  = s_axi_araddr_i - pfs_pkg::GPIO_BASE;
   wire        wr_gp   = (wr_off < pfs_pkg::GPIO_STRIDE * pfs_pkg::NPORT)
                         & (wr_off[1:0] == 2'h0);
   wire        rd_gp   = (rd_off < pfs_pkg::GPIO_STRIDE * pfs_pkg::NPORT)
                         & (rd_off[1:0] == 2'h0);
   wire [1:0]  wr_port = wr_off[5:4];
   wire [1:0]  rd_port = rd_off[5:4];
   wire        wr_ok   = wr_sel | wr_gp;

   // ---------------------------------------------------------------
   // GPIO registers and pad drive, one slice per port
   // ---------------------------------------------------------------
   logic [2:0][31:0] gout_q;
   logic [2:0][31:0] gdir_q;
   pfs_pkg::pfs_pad_t [2:0] pad_q;

   genvar p;
   generate
      for (p = 0; p < pfs_pkg::NPORT; p++) begin : g_port
         wire hit = do_wr & wr_gp & (wr_port == 2'(p));
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               gout_q[p] <= 32'h00000000;
               gdir_q[p] <= 32'h00000000;
               pad_q[p]  <= '0;
            end else begin
               if (hit && wr_off[3:0] == pfs_pkg::OFF_SET) begin
                  gout_q[p] <= gout_q[p] | (wdata_q & wbits);
               end else if (hit && wr_off[3:0] == pfs_pkg::OFF_CLR) begin
                  gout_q[p] <= gout_q[p] & ~(wdata_q & wbits);
               end
               if (hit && wr_off[3:0] == pfs_pkg::OFF_DIR) begin
                  gdir_q[p] <= (gdir_q[p] & ~wbits) |
                               (wdata_q & wbits);
               end
               pad_q[p].out <= (fmask[p] & fout[p]) |
                               (~fmask[p] & gout_q[p]);
               pad_q[p].oe  <= (fmask[p] & foe[p]) |
                               (~fmask[p] & gdir_q[p]);
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Select register and write channel
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sel_q     <= sel_boot;              // Straps held through reset
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= pfs_pkg::RESP_OK;
         awaddr_q  <= 32'h00000000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_hs) begin
            awaddr_q  <= s_axi_awaddr_i;
            awready_q <= 1'b0;
         end
         if (w_hs) begin
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
            wready_q <= 1'b0;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? pfs_pkg::RESP_OK : pfs_pkg::RESP_ERR;
            if (wr_sel) begin
               sel_q <= (sel_q & ~(wbits & pfs_pkg::SEL2_WMASK)) |
                        (wdata_q & wbits & pfs_pkg::SEL2_WMASK);
            end
         end
         if (b_done) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   logic [31:0] rd_val;
   logic        rd_hit;

   always_comb begin
      rd_val = 32'h00000000;
      rd_hit = 1'b0;
      if (s_axi_araddr_i == pfs_pkg::SEL2_ADDR) begin
         rd_val = sel_q;
         rd_hit = 1'b1;
      end else if (rd_gp) begin
         rd_hit = 1'b1;
         case (rd_off[3:0])
            pfs_pkg::OFF_PIN: rd_val = pad_s2_q[rd_port];
            pfs_pkg::OFF_SET: rd_val = gout_q[rd_port];
            pfs_pkg::OFF_DIR: rd_val = gdir_q[rd_port];
            default:          rd_val = 32'h00000000;  // Clear: write-only
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= pfs_pkg::RESP_OK;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_val;
            rresp_q   <= rd_hit ? pfs_pkg::RESP_OK : pfs_pkg::RESP_ERR;
         end
         if (r_done) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Peripheral-side returns
   // ---------------------------------------------------------------
   logic [31:0] mem_din_q;
   logic [5:0]  dbg_in_q;
   logic [3:0]  ain_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_din_q <= 32'h00000000;
         dbg_in_q  <= 6'h00;
         ain_q     <= 4'h0;
      end else begin
         mem_din_q <= pad_s2_q[1];
         dbg_in_q  <= pad_s2_q[0][31:26];
         ain_q     <= {analog_in_7, analog_in_6, analog_in_5, analog_in_4};
      end
   end

   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o  = wready_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;
   assign mem_din_o       = mem_din_q;
   assign dbg_in_o        = dbg_in_q;
   assign analog_in_en_o  = ain_q;
   assign pad_o           = pad_q;

endmodule

`default_nettype wire

// File: testbench/pfs_board.sv
// Board pins around the pin select block.
// Assumes pads settle to the driven level, else a toggling float.
`timescale 1ns/1ns
`default_nettype none

module pfs_board (
   // Clock
   input  wire logic                    clk_i,
   // Pads
   input  wire pfs_pkg::pfs_pad_t [2:0] pad_drv_i,
   output logic [2:0][31:0]             pad_lvl_o
);
   logic [31:0] float_q = 32'h55555555;

   // Undriven pins toggle, so no stale level passes a read
   always_ff @(posedge clk_i) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         pad_lvl_o[p] = (pad_drv_i[p].out & pad_drv_i[p].oe)
                      | (float_q & ~pad_drv_i[p].oe);
      end
   end
endmodule

`default_nettype wire

// File: testbench/pfs_pin_select_assertions.sv
// Port checker for the pin select block.
// Assumes one clock domain and the synchronous reset srst_i.
`timescale 1ns/1ns
`default_nettype none

module pfs_pin_select_chk (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   // Bus
   input  wire logic                    s_axi_awvalid_i,
   input  wire logic                    s_axi_awready_o,
   input  wire logic                    s_axi_wvalid_i,
   input  wire logic                    s_axi_wready_o,
   input  wire logic                    s_axi_bvalid_o,
   input  wire logic                    s_axi_arvalid_i,
   input  wire logic                    s_axi_arready_o,
   input  wire logic                    s_axi_rvalid_o,
   input  wire logic                    s_axi_rready_i,
   input  wire logic [1:0]              s_axi_rresp_o,
   input  wire logic [31:0]             s_axi_rdata_o,
   // Pins
   input  wire logic [3:0]              analog_in_en_o,
   input  wire pfs_pkg::pfs_pad_t [2:0] pad_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   pads_reset_a: assert property ($past(srst_i) |->
      pad_o[0].oe == 32'h0 && pad_o[1].oe == 32'h0 && pad_o[2].oe == 32'h0)
      else $error("pads driven right after reset");
   wr_lat_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
      else $error("write response late");
   rd_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
      s_axi_rvalid_o) else $error("read data late");
   b_busy_a: assert property (s_axi_bvalid_o |->
      !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while response pending");
   r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
      else $error("read data not held");
   err_zero_a: assert property (s_axi_rvalid_o &&
      s_axi_rresp_o == pfs_pkg::RESP_ERR |-> s_axi_rdata_o == 32'h0)
      else $error("error read carries data");
   analog_in_4_dir_a: assert property (
      analog_in_en_o[0] && $past(analog_in_en_o[0]) |-> !pad_o[1].oe[30])
      else $error("analog pin driven");
   analog_in_6_dir_a: assert property (
      analog_in_en_o[2] && $past(analog_in_en_o[2]) |-> !pad_o[2].oe[29])
      else $error("analog pin driven");
endmodule

bind pfs_pin_select pfs_pin_select_chk u_chk (.*);

`default_nettype wire

// File: testbench/pin_function_select_bank2_tb.sv
// Self-checking bench for the pin select block.
// Assumes the board model on the pads and an AXI4-Lite master here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end

module pin_function_select_bank2_tb;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0;
   logic [31:0] s_axi_araddr_i = 32'h0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = 4'hF;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
   logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_rready_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, boot_strap_pins_i = 2'h0;
   logic [31:0] mem_dout_i = 32'h12345678, mem_din_o;
   logic mem_doe_i = 1'b1, mem_oe_n_i = 1'b1, mem_we_n_i = 1'b0;
   logic [23:0] mem_addr_i = 24'h5A5A5A;
   logic [3:0] mem_cs_n_i = 4'hA, mem_bls_n_i = 4'h3;
   logic ext_clock_out_i = 1'b1;
   logic [5:0] dbg_out_i = 6'h13, dbg_oe_i = 6'h2D, dbg_in_o;
   logic [9:0] trace_i = 10'h2A5;
   logic [3:0] analog_in_en_o;
   logic [2:0][31:0] pad_i;
   pfs_pkg::pfs_pad_t [2:0] pad_o;
   logic [31:0] d;
   logic [1:0] r;
   int err_total = 0;
   int n_compared = 0;

   pfs_pin_select u_dut (.*);
   pfs_board u_board (.clk_i(clk_i), .pad_drv_i(pad_o), .pad_lvl_o(pad_i));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [31:0] a, v);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o);
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
   endtask

   // Ready raised late so the held-data case is exercised
   task automatic rd(input logic [31:0] a);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid_o);
      s_axi_rready_i <= 1'b1;
      @(posedge clk_i);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
   endtask

   task automatic rst(input logic [1:0] s);
      @(posedge clk_i);
      boot_strap_pins_i <= s;
      srst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
   endtask

   task automatic settle;
      @(posedge clk_i);
      #1;
   endtask

   function automatic logic [31:0] pa(input logic [3:0] o);
      return pfs_pkg::GPIO_BASE + pfs_pkg::GPIO_STRIDE + {28'h0, o};
   endfunction

   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst(2'h0);
      rd(pfs_pkg::SEL2_ADDR);
      `CHK(d, 32'h0EE00080)
      `CHK(pad_o[2].out[23], mem_addr_i[23])
      rst(2'h3);
      rd(pfs_pkg::SEL2_ADDR);
      `CHK(d, 32'h016000B0)
      `CHK(analog_in_en_o, 4'hB)
      $display("test reset done");
      wr(pa(pfs_pkg::OFF_DIR), 32'hFF);
      wr(pa(pfs_pkg::OFF_SET), 32'h0F);
      wr(pa(pfs_pkg::OFF_SET), 32'hF0);
      wr(pa(pfs_pkg::OFF_CLR), 32'h3C);
      rd(pa(pfs_pkg::OFF_SET));
      `CHK(d[7:0], 8'hC3)
      rd(pa(pfs_pkg::OFF_DIR));
      `CHK(d[7:0], 8'hFF)
      rd(pa(pfs_pkg::OFF_PIN));
      `CHK(d[7:0], 8'hC3)
      settle();
      `CHK(pad_o[1].oe[7:0], 8'hFF)
      `CHK(pad_o[1].out[7:0], 8'hC3)
      `CHK(mem_din_o[7:0], 8'hC3)
      $display("test gpio done");
      wr(pfs_pkg::SEL2_ADDR, 32'hFFED7FFF);
      rd(pfs_pkg::SEL2_ADDR);
      `CHK(d, 32'h0FE169FC)
      `CHK(analog_in_en_o, 4'hF)
      wr(pfs_pkg::SEL2_ADDR, 32'h00000020);
      settle();
      `CHK(analog_in_en_o, 4'h0)
      `CHK(pad_o[1].oe, 32'hFFFFFFFF)
      `CHK(pad_o[1].out, mem_dout_i)
      `CHK(pad_o[2].out[31:28], {mem_bls_n_i[0], mem_bls_n_i[1],
         mem_bls_n_i[2], mem_bls_n_i[3]})
      @(posedge clk_i);
      mem_doe_i <= 1'b0;
      wr(pfs_pkg::SEL2_ADDR, 32'h0781690C);
      settle();
      `CHK(pad_o[1].oe[7:0], 8'h00)
      `CHK(pad_o[0].oe[31:26], dbg_oe_i)
      `CHK(pad_o[0].out[31:26], dbg_out_i)
      `CHK(pad_o[0].out[25:16], trace_i)
      `CHK(pad_o[0].out[1:0], {mem_oe_n_i, mem_cs_n_i[0]})
      `CHK(pad_o[2].out[31], mem_bls_n_i[0])
      `CHK(pad_o[2].out[27:23], {mem_we_n_i, mem_cs_n_i[1], mem_cs_n_i[2],
         mem_cs_n_i[3], ext_clock_out_i})
      `CHK(pad_o[2].out[7:0], mem_addr_i[7:0])
      `CHK(pad_o[2].oe[11:0], 12'h0FF)
      $display("test functions done");
      wr(32'hE002C018, 32'h1);
      `CHK(r, pfs_pkg::RESP_ERR)
      rd(32'hE002C018);
      `CHK(r, pfs_pkg::RESP_ERR)
      `CHK(d, 32'h0)
      `CHK(dbg_in_o & dbg_oe_i, dbg_out_i & dbg_oe_i)
      $display("test unmapped done");
      print_verdict();
   end

   // Whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
endmodule

`default_nettype wire
